// ===== design/bus_idle_release_arbiter.sv
// Bus controller core: idle cycle insertion, external bus release, master arbitration.
`timescale 1ns/1ns
// Operation
// RQ1: External accesses only may get one idle state between successive bus cycles.
// RQ2: Area-change enable and reads to different areas add idle, advanced mode only.
// RQ3: Write-after-read enable adds idle before the write, in either mode.
// RQ4: Both idle insertion enables are set after reset.
// RQ5: Idle state shows next address, data floats, all strobes and selects high.
// RQ6: Release granted only in expansion mode with release enable set.
// RQ7: Low request gives low acknowledge and floats address, data, strobes, selects.
// RQ8: Internal masters run internally; external accesses wait for request withdrawal.
// RQ9: With drop output enable, pending external access drives drop output low.
// RQ10: Request going high raises acknowledge and ends the released state.
// RQ11: Release request beats a simultaneous internal external-access request.
// RQ12: Highest-priority requester is acknowledged and keeps bus until withdrawn.
// RQ13: Transfer controller outranks the CPU.
// RQ14: Internal-bus accesses proceed alongside external bus release.
// RQ15: CPU hands bus over only between cycles, never inside split accesses.
// RQ16: Sleeping CPU gives up the bus at once to the transfer controller.
// RQ17: Transfer controller releases only between its vector, info and data steps.
// RQ18: Release granted only after the current external cycle completes.
// RQ19: Power-on reset resets at once, abandoning any bus cycle.
// RQ20: Manual reset keeps state, finishes external cycle ignoring wait.
// RQ21: Module stop values all-ones or EFFF stop release during sleep.
// RQ22: No idle state when no insertion condition holds or enable is clear.
module bus_idle_release_arbiter (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic manual_rst_n,
	input wire logic idle_between_areas_enable,
	input wire logic idle_write_after_read_enable,
	input wire logic bus_release_enable,
	input wire logic request_drop_output_enable,
	input wire logic advanced_mode,
	input wire logic expansion_mode,
	input wire logic sleep_mode,
	input wire logic [bus_idle_release_pkg::MSTP_W-1:0] module_stop_control,
	input wire logic cpu_req,
	input wire logic cpu_locked,
	output logic cpu_ack,
	input wire logic xfer_req,
	input wire logic xfer_locked,
	output logic xfer_ack,
	input wire logic acc_valid,
	input wire logic acc_external,
	input wire logic acc_write,
	input wire logic [1:0] acc_byte_en,
	input wire logic [2:0] acc_states,
	input wire logic [bus_idle_release_pkg::AREA_W-1:0] acc_area,
	input wire logic [bus_idle_release_pkg::ADDR_W-1:0] acc_addr,
	input wire logic [bus_idle_release_pkg::DATA_W-1:0] acc_wdata,
	output logic acc_ready,
	output logic acc_done,
	output logic [bus_idle_release_pkg::DATA_W-1:0] acc_rdata,
	output logic idle_state,
	input wire logic wait_n,
	input wire logic ext_bus_request_n,
	output logic bus_ack_n,
	output logic request_drop_out_n,
	output logic [bus_idle_release_pkg::ADDR_W-1:0] addr_out,
	output logic addr_oe,
	input wire logic [bus_idle_release_pkg::DATA_W-1:0] data_in,
	output logic [bus_idle_release_pkg::DATA_W-1:0] data_out,
	output logic data_oe,
	output logic [7:0] area_select_n,
	output logic address_strobe_n,
	output logic read_strobe_n,
	output logic upper_write_strobe_n,
	output logic lower_write_strobe_n,
	output logic ctl_oe
);
	import bus_idle_release_pkg::*;

	ctl_state_t state_r;
	ctl_state_t state_nxt;
	owner_t owner_r;
	owner_t owner_nxt;
	logic idle_area_en_r;
	logic idle_war_en_r;
	logic last_read_r;
	logic [AREA_W-1:0] last_area_r;
	logic last_valid_r;
	logic [1:0] idle_cnt_r;
	logic mrst_pend_r;
	logic release_ok;
	logic release_want;
	logic need_idle;
	logic start_cycle;
	logic cyc_busy;
	logic cyc_done;
	logic [DATA_W-1:0] cyc_data_out;
	logic cyc_data_oe;
	logic [7:0] cyc_cs_n;
	logic cyc_as_n;
	logic cyc_rd_n;
	logic cyc_hwr_n;
	logic cyc_lwr_n;

	// Release is disabled by sleeping with certain module stop settings.
	function automatic logic release_stopped(input logic slp, input logic [MSTP_W-1:0] m);
		release_stopped = slp && (m == MSTP_STOP_ALL || m == MSTP_STOP_ALT);
	endfunction

	// ----------------------------------------------------------------
	// Idle enables
	// ----------------------------------------------------------------
	// Enables are latched from the ports; reset leaves insertion on, but the port
	// values take over on the first clock, before any cycle has history to need idle.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			idle_area_en_r <= IDLE_AREA_EN_RST; // [RQ4]
			idle_war_en_r <= IDLE_WAR_EN_RST; // [RQ4]
		end else begin
			idle_area_en_r <= idle_between_areas_enable;
			idle_war_en_r <= idle_write_after_read_enable;
		end
	end

	// ----------------------------------------------------------------
	// Release qualification
	// ----------------------------------------------------------------
	assign release_ok = expansion_mode && bus_release_enable
		&& !release_stopped(sleep_mode, module_stop_control); // [RQ6] [RQ21]
	assign release_want = release_ok && !ext_bus_request_n;

	// Idle needed for the pending external access relative to the last one.
	always_comb begin
		need_idle = 1'b0;
		if (last_valid_r && last_read_r) begin
			if (acc_write && idle_war_en_r) begin
				need_idle = 1'b1; // [RQ3]
			end else if (!acc_write && advanced_mode && idle_area_en_r
				&& acc_area != last_area_r) begin
				need_idle = 1'b1; // [RQ2]
			end
		end
	end

	// ----------------------------------------------------------------
	// Main state machine
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		start_cycle = 1'b0;
		case (state_r)
			ST_READY: begin
				if (release_want) begin
					state_nxt = ST_RELEASED; // [RQ11] [RQ7]
				end else if (acc_valid && acc_external && !mrst_pend_r) begin
					if (need_idle) begin
						state_nxt = ST_IDLE; // [RQ1]
					end else begin
						start_cycle = 1'b1; // [RQ22]
						state_nxt = ST_ACCESS;
					end
				end
			end
			ST_IDLE: begin
				if (release_want) begin
					state_nxt = ST_RELEASED; // [RQ11]
				end else if (idle_cnt_r == IDLE_CYC_W) begin
					start_cycle = 1'b1;
					state_nxt = ST_ACCESS;
				end
			end
			ST_ACCESS: begin
				if (cyc_done) begin
					state_nxt = ST_READY; // [RQ18]
				end
			end
			ST_RELEASED: begin
				if (ext_bus_request_n || !release_ok) begin
					state_nxt = ST_READY; // [RQ10]
				end
			end
			default: state_nxt = ST_READY;
		endcase
	end

	// Power-on reset abandons everything; manual reset leaves the state alone.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_r <= ST_READY; // [RQ19]
			idle_cnt_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			if (state_r == ST_IDLE) begin
				idle_cnt_r <= idle_cnt_r + 2'h1;
			end else begin
				idle_cnt_r <= 2'h1;
			end
		end
	end

	// A manual reset lets the running cycle end without waits, then holds new
	// external cycles off until the manual reset is released; one already in its idle state still starts.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mrst_pend_r <= 1'b0;
		end else begin
			mrst_pend_r <= !manual_rst_n; // [RQ20]
		end
	end

	// History of the last external cycle, for idle decisions.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			last_valid_r <= 1'b0;
			last_read_r <= 1'b0;
			last_area_r <= '0;
		end else if (start_cycle) begin
			last_valid_r <= 1'b1;
			last_read_r <= !acc_write;
			last_area_r <= acc_area;
		end else if (state_r == ST_RELEASED) begin
			last_valid_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Internal arbitration
	// ----------------------------------------------------------------
	// Another master may take over only when the current one is not locked inside a
	// split or multi-step operation; a sleeping CPU is never locked.
	always_comb begin
		owner_nxt = owner_r;
		case (owner_r)
			OWN_NONE: begin
				if (xfer_req) begin
					owner_nxt = OWN_XFER; // [RQ13]
				end else if (cpu_req) begin
					owner_nxt = OWN_CPU;
				end
			end
			OWN_CPU: begin
				if (xfer_req && (sleep_mode || !cpu_locked)) begin
					owner_nxt = OWN_XFER; // [RQ15] [RQ16]
				end else if (!cpu_req) begin
					owner_nxt = OWN_NONE;
				end
			end
			OWN_XFER: begin
				if (!xfer_req && !xfer_locked) begin
					owner_nxt = cpu_req ? OWN_CPU : OWN_NONE; // [RQ17]
				end
			end
			default: owner_nxt = OWN_NONE;
		endcase
	end

	// Ownership never changes in the middle of an external cycle.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			owner_r <= OWN_NONE;
		end else if (state_r != ST_ACCESS && state_r != ST_IDLE) begin
			owner_r <= owner_nxt;
		end
	end

	assign cpu_ack = owner_r == OWN_CPU; // [RQ12]
	assign xfer_ack = owner_r == OWN_XFER; // [RQ12]

	// ----------------------------------------------------------------
	// Access handshake
	// ----------------------------------------------------------------
	// Internal accesses are always accepted, even while released; external
	// ones only at the start of their own cycle.
	assign acc_ready = acc_valid && (!acc_external ? 1'b1 : start_cycle); // [RQ14] [RQ8]
	assign idle_state = state_r == ST_IDLE;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			request_drop_out_n <= 1'b1;
			bus_ack_n <= 1'b1;
		end else begin
			// Only asked for once the bus is really out, never on the granting edge.
			request_drop_out_n <= !(state_r == ST_RELEASED && state_nxt == ST_RELEASED
				&& request_drop_output_enable
				&& acc_valid && acc_external); // [RQ9]
			bus_ack_n <= state_nxt != ST_RELEASED; // [RQ7] [RQ10]
		end
	end

	// ----------------------------------------------------------------
	// Pins
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			addr_out <= '0;
		end else if (acc_valid && acc_external && state_r != ST_ACCESS) begin
			addr_out <= acc_addr; // [RQ5]
		end
	end

	assign addr_oe = state_r != ST_RELEASED; // [RQ7]
	assign ctl_oe = state_r != ST_RELEASED; // [RQ7]
	assign data_oe = cyc_data_oe && state_r == ST_ACCESS; // [RQ5]
	assign data_out = cyc_data_out;
	assign area_select_n = cyc_cs_n; // [RQ5]
	assign address_strobe_n = cyc_as_n;
	assign read_strobe_n = cyc_rd_n; // [RQ18]
	assign upper_write_strobe_n = cyc_hwr_n;
	assign lower_write_strobe_n = cyc_lwr_n;
	assign acc_done = cyc_done;

	ext_cycle_gen u_cycle (
		.ref_clk(ref_clk),
		.por_rst_n(rst_n),
		.start(start_cycle),
		.is_write(acc_write),
		.byte_en(acc_byte_en),
		.states(acc_states),
		.area(acc_area),
		.wdata(acc_wdata),
		.wait_n(wait_n),
		.ignore_wait(mrst_pend_r),
		.busy(cyc_busy),
		.done(cyc_done),
		.rdata(acc_rdata),
		.data_in(data_in),
		.data_out(cyc_data_out),
		.data_oe(cyc_data_oe),
		.area_select_n(cyc_cs_n),
		.address_strobe_n(cyc_as_n),
		.read_strobe_n(cyc_rd_n),
		.upper_write_strobe_n(cyc_hwr_n),
		.lower_write_strobe_n(cyc_lwr_n)
	);

endmodule

// ===== design/bus_idle_release_pkg.sv
// Shared constants and types for the idle-cycle, bus-release and arbitration block.
package bus_idle_release_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int AREA_W = 3;
	localparam int MSTP_W = 16;

	// ----------------------------------------------------------------
	// Reset values and special register values
	// ----------------------------------------------------------------
	localparam logic IDLE_AREA_EN_RST = 1'b1;
	localparam logic IDLE_WAR_EN_RST = 1'b1;
	localparam logic [MSTP_W-1:0] MSTP_STOP_ALL = 16'hFFFF;
	localparam logic [MSTP_W-1:0] MSTP_STOP_ALT = 16'hEFFF;

	// ----------------------------------------------------------------
	// Timing: idle state length and its conversion to clock cycles
	// ----------------------------------------------------------------
	localparam int IDLE_STATES = 1;
	localparam int STATE_NS = 20;
	localparam int CLK_NS = 20;
	localparam int IDLE_CYC = (IDLE_STATES * STATE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] IDLE_CYC_W = IDLE_CYC[1:0];

	// ----------------------------------------------------------------
	// Controller states and bus owners
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_READY,
		ST_IDLE,
		ST_ACCESS,
		ST_RELEASED
	} ctl_state_t;

	typedef enum logic [1:0] {
		OWN_NONE,
		OWN_CPU,
		OWN_XFER
	} owner_t;

endpackage

// ===== design/ext_cycle_gen.sv
// External cycle sequencer: drives strobes for one external read or write.
`timescale 1ns/1ns
module ext_cycle_gen (
	input wire logic ref_clk,
	input wire logic por_rst_n,
	input wire logic start,
	input wire logic is_write,
	input wire logic [1:0] byte_en,
	input wire logic [2:0] states,
	input wire logic [bus_idle_release_pkg::AREA_W-1:0] area,
	input wire logic [bus_idle_release_pkg::DATA_W-1:0] wdata,
	input wire logic wait_n,
	input wire logic ignore_wait,
	output logic busy,
	output logic done,
	output logic [bus_idle_release_pkg::DATA_W-1:0] rdata,
	input wire logic [bus_idle_release_pkg::DATA_W-1:0] data_in,
	output logic [bus_idle_release_pkg::DATA_W-1:0] data_out,
	output logic data_oe,
	output logic [7:0] area_select_n,
	output logic address_strobe_n,
	output logic read_strobe_n,
	output logic upper_write_strobe_n,
	output logic lower_write_strobe_n
);
	import bus_idle_release_pkg::*;

	logic [2:0] cnt_r;
	logic wr_r;
	logic [1:0] be_r;

	// ----------------------------------------------------------------
	// Cycle counter
	// ----------------------------------------------------------------
	// The last state stretches while the wait input is low, unless a manual
	// reset asked for the cycle to be completed without waits.
	always_ff @(posedge ref_clk) begin
		if (!por_rst_n) begin
			cnt_r <= 3'h0;
			busy <= 1'b0;
			done <= 1'b0;
			wr_r <= 1'b0;
			be_r <= 2'h0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				busy <= 1'b1;
				cnt_r <= states;
				wr_r <= is_write;
				be_r <= byte_en;
			end else if (busy) begin
				if (cnt_r > 3'h1) begin
					cnt_r <= cnt_r - 3'h1;
				end else if (wait_n || ignore_wait) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Strobes and data
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!por_rst_n) begin
			area_select_n <= 8'hFF;
			address_strobe_n <= 1'b1;
			read_strobe_n <= 1'b1;
			upper_write_strobe_n <= 1'b1;
			lower_write_strobe_n <= 1'b1;
			data_out <= 16'h0000;
			data_oe <= 1'b0;
			rdata <= 16'h0000;
		end else if (start && !busy) begin
			area_select_n <= ~(8'h01 << area);
			address_strobe_n <= 1'b0;
			read_strobe_n <= is_write;
			upper_write_strobe_n <= ~(is_write & byte_en[1]);
			lower_write_strobe_n <= ~(is_write & byte_en[0]);
			data_out <= wdata;
			data_oe <= is_write;
		end else if (busy && cnt_r <= 3'h1 && (wait_n || ignore_wait)) begin
			area_select_n <= 8'hFF;
			address_strobe_n <= 1'b1;
			read_strobe_n <= 1'b1;
			upper_write_strobe_n <= 1'b1;
			lower_write_strobe_n <= 1'b1;
			data_oe <= 1'b0;
			if (!wr_r) begin
				rdata <= data_in;
			end
		end
	end

endmodule

// ===== dv/bus_far_side_model.sv
// Far side model: an outside bus master plus a memory that answers external reads.
`timescale 1ns/1ns
module bus_far_side_model (
	input wire logic ref_clk,
	input wire logic grab,
	input wire logic slow,
	input wire logic hold_wait,
	input wire logic bus_ack_n,
	input wire logic request_drop_out_n,
	input wire logic [bus_idle_release_pkg::ADDR_W-1:0] addr_out,
	input wire logic read_strobe_n,
	input wire logic address_strobe_n,
	output logic ext_bus_request_n,
	output logic wait_n,
	output logic [bus_idle_release_pkg::DATA_W-1:0] data_in
);
	import bus_idle_release_pkg::*;
	logic drop_seen_r = 1'b0;
	logic as_prev_r = 1'b1;
	logic [DATA_W-1:0] noise_r = 16'h0;
	// A drop request is honoured once per tenure; the master asks again only after grab falls.
	always_ff @(posedge ref_clk) begin
		drop_seen_r <= grab && (drop_seen_r || (!request_drop_out_n && !bus_ack_n));
		ext_bus_request_n <= !(grab && !drop_seen_r);
	end
	always_ff @(posedge ref_clk) begin
		as_prev_r <= address_strobe_n;
		noise_r <= ~noise_r ^ 16'h1;
	end
	assign wait_n = !(!address_strobe_n && (hold_wait || (slow && as_prev_r)));
	// Outside reads the data lines carry a changing pattern, never a stale value.
	assign data_in = !read_strobe_n ? addr_out[15:0] ^ 16'hA5C3 : noise_r;
endmodule

// ===== dv/bus_idle_release_properties.sv
// Concurrent checks on the idle, release and arbitration behaviour of the bus controller.
`timescale 1ns/1ns
module bus_idle_release_properties (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic bus_release_enable,
	input wire logic request_drop_output_enable,
	input wire logic expansion_mode,
	input wire logic sleep_mode,
	input wire logic [bus_idle_release_pkg::MSTP_W-1:0] module_stop_control,
	input wire logic cpu_req,
	input wire logic cpu_locked,
	input wire logic cpu_ack,
	input wire logic xfer_ack,
	input wire logic acc_valid,
	input wire logic acc_external,
	input wire logic acc_ready,
	input wire logic idle_state,
	input wire logic ext_bus_request_n,
	input wire logic bus_ack_n,
	input wire logic request_drop_out_n,
	input wire logic addr_oe,
	input wire logic data_oe,
	input wire logic [7:0] area_select_n,
	input wire logic address_strobe_n,
	input wire logic read_strobe_n,
	input wire logic upper_write_strobe_n,
	input wire logic lower_write_strobe_n,
	input wire logic ctl_oe
);
	import bus_idle_release_pkg::*;
	wire logic stop_pat;
	wire logic rel_ok;
	// Sleep with either stop pattern silently disables release, so it is part of the condition.
	assign stop_pat = module_stop_control == MSTP_STOP_ALL || module_stop_control == MSTP_STOP_ALT;
	assign rel_ok = bus_release_enable && expansion_mode && !(sleep_mode && stop_pat);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	a_idle_one_state: assert property (
		idle_state |-> acc_valid && acc_external ##1 !idle_state) else $error("idle state wrong");
	a_idle_pins_high: assert property (
		idle_state |-> &area_select_n && address_strobe_n && read_strobe_n &&
		upper_write_strobe_n && lower_write_strobe_n && !data_oe) else $error("idle pins wrong");
	a_release_floats: assert property (
		!bus_ack_n |-> !addr_oe && !ctl_oe && !data_oe) else $error("released bus driven");
	a_grant_has_cause: assert property (
		$fell(bus_ack_n) |-> $past(!ext_bus_request_n && rel_ok)) else $error("grant uncaused");
	a_ext_held_back: assert property (
		acc_valid && acc_external && (!bus_ack_n || (!ext_bus_request_n && rel_ok))
		|-> !acc_ready) else $error("external access taken");
	a_drop_has_cause: assert property (
		$fell(request_drop_out_n) |-> $past(request_drop_output_enable && !bus_ack_n &&
		acc_valid && acc_external)) else $error("drop output uncaused");
	a_release_end: assert property (
		$rose(bus_ack_n) |-> $past(ext_bus_request_n || !rel_ok)) else $error("ack rose early");
	a_ack_exclusive: assert property (
		!(cpu_ack && xfer_ack)) else $error("two masters acknowledged");
	a_cpu_lock_keep: assert property (
		cpu_ack && cpu_req && cpu_locked && !sleep_mode |=> cpu_ack) else $error("split broken");
	a_no_grant_mid: assert property (
		!address_strobe_n || !read_strobe_n |-> bus_ack_n) else $error("grant inside cycle");
endmodule

bind bus_idle_release_arbiter bus_idle_release_properties bus_idle_release_properties_i (.*);

// ===== dv/tb_bus_idle_release_arbiter.sv
// Self-checking bench for the idle, release and arbitration block.
`timescale 1ns/1ns
module tb_bus_idle_release_arbiter;
	import bus_idle_release_pkg::*;
	typedef struct {logic idle; logic rd; logic [DATA_W-1:0] data;} note_t;
	logic ref_clk = 1'b0, rst_n = 1'b0, manual_rst_n = 1'b1;
	logic idle_between_areas_enable = 1'b1, idle_write_after_read_enable = 1'b1;
	logic bus_release_enable = 1'b0, request_drop_output_enable = 1'b0;
	logic advanced_mode = 1'b1, expansion_mode = 1'b1, sleep_mode = 1'b0;
	logic [MSTP_W-1:0] module_stop_control = 16'h0;
	logic cpu_req = 1'b0, cpu_locked = 1'b0, xfer_req = 1'b0, xfer_locked = 1'b0;
	logic acc_valid = 1'b0, acc_external = 1'b0, acc_write = 1'b0;
	logic [1:0] acc_byte_en = 2'h3;
	logic [2:0] acc_states = 3'h2;
	logic [AREA_W-1:0] acc_area = 3'h0;
	logic [ADDR_W-1:0] acc_addr = 24'h0;
	logic [DATA_W-1:0] acc_wdata = 16'h0;
	logic grab = 1'b0, slow = 1'b0, hold_wait = 1'b0;
	logic cpu_ack, xfer_ack, acc_ready, acc_done, idle_state, wait_n, ext_bus_request_n;
	logic bus_ack_n, request_drop_out_n, addr_oe, data_oe, ctl_oe;
	logic address_strobe_n, read_strobe_n, upper_write_strobe_n, lower_write_strobe_n;
	logic [DATA_W-1:0] acc_rdata, data_in, data_out;
	logic [ADDR_W-1:0] addr_out;
	logic [7:0] area_select_n;
	int failures = 0, tests_run = 0, rnd;
	logic hist_ok = 1'b0, last_rd = 1'b0, seen_idle = 1'b0;
	logic [AREA_W-1:0] last_area = 3'h0;
	note_t q[$];
	note_t nm;

	bus_idle_release_arbiter bus_idle_release_arbiter_i (.*);
	bus_far_side_model bus_far_side_model_i (.ref_clk, .grab, .slow, .hold_wait, .bus_ack_n,
		.request_drop_out_n, .addr_out, .read_strobe_n, .address_strobe_n, .ext_bus_request_n,
		.wait_n, .data_in);

	always #(CLK_NS / 2) ref_clk = ~ref_clk;

	task automatic check(input string nme, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nme, exp, got);
		end
	endtask

	task automatic print_verdict();
		if (failures == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Polls at the falling edge so that combinational flags have settled.
	task automatic waitfor(input int sel, input int lim);
		logic [6:0] w;
		for (int n = 0; n < lim; n++) begin
			@(negedge ref_clk);
			w = {cpu_ack, xfer_ack, !request_drop_out_n, bus_ack_n, !bus_ack_n, acc_done, acc_ready};
			if (w[sel] === 1'b1)
				return;
		end
		check("wait", 16'(sel), 16'hFFFF);
	endtask

	task automatic acc(input logic wr, input logic [AREA_W-1:0] ar);
		note_t nt;
		nt.idle = hist_ok && last_rd && (wr ? idle_write_after_read_enable :
			advanced_mode && idle_between_areas_enable && ar != last_area);
		nt.rd = !wr;
		acc_addr = ADDR_W'($urandom);
		nt.data = acc_addr[15:0] ^ 16'hA5C3;
		acc_write = wr;
		acc_area = ar;
		acc_states = 3'(2 + $urandom_range(1));
		acc_byte_en = 2'($urandom_range(3, 1));
		acc_wdata = 16'($urandom);
		acc_external = 1'b1;
		acc_valid = 1'b1;
		q.push_back(nt);
		waitfor(0, 300);
		@(posedge ref_clk);
		#2 acc_valid = 1'b0;
		waitfor(1, 300);
		@(posedge ref_clk);
		#2 hist_ok = 1'b1;
		last_rd = !wr;
		last_area = ar;
	endtask

	always @(posedge ref_clk) begin
		if (acc_done === 1'b1 && rst_n === 1'b1 && q.size() > 0) begin
			nm = q.pop_front();
			check("idle", 16'(nm.idle), 16'(seen_idle));
			if (nm.rd)
				check("rdata", nm.data, acc_rdata);
			seen_idle = 1'b0;
		end
		if (idle_state === 1'b1)
			seen_idle = 1'b1;
	end

	initial begin
		#(CLK_NS * 20000);
		check("watchdog", 16'h0, 16'h1);
		print_verdict();
	end

	initial begin
		rnd = $urandom(32'hC013);
		repeat (12) @(posedge ref_clk);
		#2 rst_n = 1'b1;
		cpu_req = 1'b1;
		waitfor(6, 20);
		for (int i = 0; i < 8; i++) begin
			{idle_write_after_read_enable, idle_between_areas_enable, advanced_mode} = 3'(i);
			slow = i[1];
			acc(0, 3'(i));
			acc(0, 3'(i + 1));
			acc(0, 3'(i + 1));
			acc(1, 3'(i));
			acc(1, 3'(i));
		end
		for (int i = 0; i < 4; i++) begin
			bus_release_enable = i != 0;
			expansion_mode = i != 1;
			sleep_mode = i >= 2;
			module_stop_control = i == 2 ? MSTP_STOP_ALL : MSTP_STOP_ALT;
			grab = 1'b1;
			repeat (8) @(posedge ref_clk);
			#2 check("bus_ack_n", 16'h1, 16'(bus_ack_n));
			grab = 1'b0;
			repeat (3) @(posedge ref_clk);
		end
		#2 sleep_mode = 1'b0;
		bus_release_enable = 1'b1;
		expansion_mode = 1'b1;
		fork
			acc(0, 3'h4);
			begin repeat (2) @(posedge ref_clk); #2 grab = 1'b1; end
		join
		waitfor(2, 10);
		check("addr_oe", 16'h0, 16'(addr_oe));
		check("ctl_oe", 16'h0, 16'(ctl_oe));
		acc_external = 1'b0;
		acc_valid = 1'b1;
		waitfor(0, 10);
		@(posedge ref_clk);
		#2 acc_valid = 1'b0;
		request_drop_output_enable = 1'b1;
		hist_ok = 1'b0;
		fork
			acc(0, 3'h2);
			waitfor(4, 20);
		join
		grab = 1'b0;
		cpu_locked = 1'b1;
		xfer_req = 1'b1;
		repeat (4) @(posedge ref_clk);
		#2 check("cpu_ack", 16'h1, 16'(cpu_ack));
		cpu_locked = 1'b0;
		waitfor(5, 10);
		xfer_locked = 1'b1;
		xfer_req = 1'b0;
		repeat (4) @(posedge ref_clk);
		#2 check("xfer_ack", 16'h1, 16'(xfer_ack));
		xfer_locked = 1'b0;
		waitfor(6, 10);
		cpu_locked = 1'b1;
		sleep_mode = 1'b1;
		xfer_req = 1'b1;
		waitfor(5, 10);
		xfer_req = 1'b0;
		cpu_locked = 1'b0;
		sleep_mode = 1'b0;
		waitfor(6, 10);
		hold_wait = 1'b1;
		fork
			acc(0, 3'h1);
			begin repeat (3) @(posedge ref_clk); #2 manual_rst_n = 1'b0; end
		join
		manual_rst_n = 1'b1;
		hold_wait = 1'b0;
		acc_valid = 1'b1;
		acc_write = 1'b0;
		waitfor(0, 10);
		@(posedge ref_clk);
		#2 acc_valid = 1'b0;
		rst_n = 1'b0;
		@(posedge ref_clk);
		#2 check("read_strobe_n", 16'h1, 16'(read_strobe_n));
		repeat (2) @(posedge ref_clk);
		#2 rst_n = 1'b1;
		waitfor(6, 20);
		print_verdict();
	end
endmodule
